// >>> hdl/amws_write_seq.sv
// Write sequencer of the asynchronous external memory interface.
// Behaviour
// - At the first setup start of a word the setup, strobe and hold counts are loaded from the space's config.
// - At setup start address, page lines and write data are driven valid.
// - At setup start the direction pin goes low unless already low.
// - At setup start the space's chip select goes low unless already low or in select-strobe mode.
// - The write strobe is low from strobe start for the programmed strobe length.
// - The write strobe returns high in the first hold cycle.
// - After hold the address, page and data pins may change or be released.
// - After the last hold the direction pin and chip select rise unless a same-space write follows; after other holds they stay active.
// - A further sub-access starts its setup right after hold, with no turnaround.
// - Sub-accesses of one word keep the timing counts loaded for the first one.
// - With the word done and nothing waiting, the sequencer returns to idle.
// - With a request for another space waiting at word completion, it goes straight to turnaround; one for the same space goes straight to setup.
// - Select-strobe operation is used only when the space's select-strobe bit is 1.
// - In select-strobe mode chip select is low only in the strobe phase.
// - Turnaround waits the space's count, none after a same-space write, one if zero.
// - Output enable stays high throughout a write.
`timescale 1ns/1ns
module amws_write_seq
    import amws_pkg::*;
(
    input  wire logic                     clock_i,
    input  wire logic                     rst_n_i,
    input  wire amws_space_cfg_type [SPACES-1:0] chip_space_config_i,
    input  wire logic                     req_valid_i,
    input  wire amws_req_type             req_i,
    output logic                          req_ready_o,
    output logic                          done_o,
    output logic [XA_W-1:0]               external_address_bus_o,
    output logic [1:0]                    memory_page_lines_o,
    output logic [XD_W-1:0]               external_data_bus_o,
    output logic                          external_data_bus_oe_o,
    output logic [SPACES-1:0]             chip_select_n_o,
    output logic                          direction_indicator_n_o,
    output logic                          write_strobe_n_o,
    output logic                          output_enable_n_o
);

    typedef struct packed {
        amws_phase_type     phase;
        amws_req_type       req;
        amws_space_cfg_type tim;
        logic [1:0]         sub;
        amws_pins_type      pins;
        logic               ready;
        logic               done;
    } amws_seq_state_type;

    amws_seq_state_type st_r;
    amws_seq_state_type st_nxt;
    logic               tload;
    logic [CNT_W-1:0]   tval;
    logic [CNT_W-1:0]   cnt;
    logic [CNT_W-1:0]   cnt_nxt;
    logic               take;
    logic               new_req;
    logic               first;
    logic               hold_end;
    logic               is_last;

    function automatic logic [1:0] last_sub(input logic narrow8);
        last_sub = narrow8 ? LAST_X8 : LAST_X16;
    endfunction : last_sub

    // A zero turnaround field still costs one cycle; N > 0 costs N cycles.
    function automatic logic [CNT_W-1:0] ta_load(input logic [1:0] ta);
        ta_load = (ta == TA_ZERO) ? CNT_ZERO : CNT_W'(ta - 2'h1);
    endfunction : ta_load

    function automatic logic [XA_W-1:0] ext_addr(input amws_req_type r,
                                                 input logic narrow8,
                                                 input logic [1:0] sub);
        ext_addr = narrow8 ? {r.word_addr, sub} : {1'b0, r.word_addr, sub[0]};
    endfunction : ext_addr

    function automatic logic [XD_W-1:0] lane(input amws_req_type r,
                                             input logic narrow8,
                                             input logic [1:0] sub);
        logic [WD_W-1:0] sh;
        sh = narrow8 ? (r.data >> {sub, 3'h0}) : (r.data >> {sub[0], 4'h0});
        lane = narrow8 ? {8'h00, sh[7:0]} : sh[XD_W-1:0];
    endfunction : lane

    amws_phase_timer u_timer (
        .clock_i    (clock_i),
        .rst_n_i    (rst_n_i),
        .load_i     (tload),
        .load_val_i (tval),
        .count_o    (cnt)
    );

    assign take     = req_valid_i & st_r.ready;
    assign hold_end = (st_r.phase == ST_HOLD) && (cnt == CNT_ZERO);
    assign is_last  = (st_r.sub == last_sub(st_r.tim.narrow8));

    always_comb begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        new_req     = 1'b0;
        first       = 1'b0;
        tload       = 1'b0;
        tval        = CNT_ZERO;
        unique case (st_r.phase)
            ST_IDLE: begin
                if (take) begin
                    new_req      = 1'b1;
                    st_nxt.phase = ST_TURN;
                end
            end
            ST_TURN: begin
                if (cnt == CNT_ZERO) begin
                    st_nxt.phase = ST_SETUP;
                    first        = 1'b1;
                end
            end
            ST_SETUP: begin
                if (cnt == CNT_ZERO) begin
                    st_nxt.phase = ST_STROBE;
                end
            end
            ST_STROBE: begin
                if (cnt == CNT_ZERO) begin
                    st_nxt.phase = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (cnt == CNT_ZERO) begin
                    if (!is_last) begin
                        st_nxt.phase = ST_SETUP;
                        st_nxt.sub   = st_r.sub + 2'h1;
                    end else begin
                        st_nxt.done = 1'b1;
                        if (take && (req_i.space == st_r.req.space)) begin
                            new_req      = 1'b1;
                            first        = 1'b1;
                            st_nxt.phase = ST_SETUP;
                        end else if (take) begin
                            new_req      = 1'b1;
                            st_nxt.phase = ST_TURN;
                        end else begin
                            st_nxt.phase = ST_IDLE;
                        end
                    end
                end
            end
            default: begin
                st_nxt.phase = ST_IDLE;
            end
        endcase

        if (new_req) begin
            st_nxt.req = req_i;
            st_nxt.sub = SUB_FIRST;
        end
        // Timing is latched per request only; sub-accesses reuse it.
        if (first) begin
            st_nxt.tim = chip_space_config_i[st_nxt.req.space];
        end

        if (st_nxt.phase != st_r.phase) begin
            tload = 1'b1;
            unique case (st_nxt.phase)
                ST_TURN:   tval = ta_load(chip_space_config_i[req_i.space].turnaround_cycles);
                ST_SETUP:  tval = CNT_W'(st_nxt.tim.w_setup);
                ST_STROBE: tval = st_nxt.tim.w_strobe;
                ST_HOLD:   tval = CNT_W'(st_nxt.tim.w_hold);
                default:   tval = CNT_ZERO;
            endcase
        end

        st_nxt.pins.output_enable_n = 1'b1;
        if (st_nxt.phase != st_r.phase) begin
            unique case (st_nxt.phase)
                ST_SETUP: begin
                    st_nxt.pins.external_address_bus =
                        ext_addr(st_nxt.req, st_nxt.tim.narrow8, st_nxt.sub);
                    st_nxt.pins.memory_page_lines = st_nxt.req.bank;
                    st_nxt.pins.external_data_bus =
                        lane(st_nxt.req, st_nxt.tim.narrow8, st_nxt.sub);
                    st_nxt.pins.data_oe               = 1'b1;
                    st_nxt.pins.direction_indicator_n = 1'b0;
                    st_nxt.pins.chip_select_n         = CS_IDLE;
                    if (!st_nxt.tim.select_strobe) begin
                        st_nxt.pins.chip_select_n[st_nxt.req.space] = 1'b0;
                    end
                end
                ST_STROBE: begin
                    st_nxt.pins.write_strobe_n = 1'b0;
                    if (st_nxt.tim.select_strobe) begin
                        st_nxt.pins.chip_select_n[st_nxt.req.space] = 1'b0;
                    end
                end
                ST_HOLD: begin
                    st_nxt.pins.write_strobe_n = 1'b1;
                    if (st_nxt.tim.select_strobe) begin
                        st_nxt.pins.chip_select_n = CS_IDLE;
                    end
                end
                default: begin
                    // Leaving hold for good: release the bus and the selects.
                    st_nxt.pins.data_oe               = 1'b0;
                    st_nxt.pins.chip_select_n         = CS_IDLE;
                    st_nxt.pins.direction_indicator_n = 1'b1;
                end
            endcase
        end

        // The accept window must be known one cycle ahead, because the ready
        // output is registered.
        cnt_nxt = tload ? tval : ((cnt == CNT_ZERO) ? CNT_ZERO : cnt - CNT_ONE);
        st_nxt.ready = (st_nxt.phase == ST_IDLE) ||
                       ((st_nxt.phase == ST_HOLD) && (cnt_nxt == CNT_ZERO) &&
                        (st_nxt.sub == last_sub(st_nxt.tim.narrow8)));
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r       <= '0;
            st_r.phase <= ST_IDLE;
            st_r.pins  <= PINS_RESET;
            st_r.ready <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign req_ready_o             = st_r.ready;
    assign done_o                  = st_r.done;
    assign external_address_bus_o  = st_r.pins.external_address_bus;
    assign memory_page_lines_o     = st_r.pins.memory_page_lines;
    assign external_data_bus_o     = st_r.pins.external_data_bus;
    assign external_data_bus_oe_o  = st_r.pins.data_oe;
    assign chip_select_n_o         = st_r.pins.chip_select_n;
    assign direction_indicator_n_o = st_r.pins.direction_indicator_n;
    assign write_strobe_n_o        = st_r.pins.write_strobe_n;
    assign output_enable_n_o       = st_r.pins.output_enable_n;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_hold_end;
        hold_end;
    endsequence
    sequence s_word_done;
        s_hold_end ##0 is_last && !take;
    endsequence
    sequence s_sub_next;
        s_hold_end ##0 !is_last;
    endsequence

    property p_oe_high;
        output_enable_n_o == 1'b1;
    endproperty
    a_oe_high: assert property (p_oe_high) else $error("Output enable low in a write.");

    property p_setup_pins;
        $rose(st_r.phase == ST_SETUP) |-> !direction_indicator_n_o && external_data_bus_oe_o
            && (st_r.tim.select_strobe || !chip_select_n_o[st_r.req.space]);
    endproperty
    a_setup_pins: assert property (p_setup_pins) else $error("Setup pins wrong.");

    property p_strobe_load;
        $rose(st_r.phase == ST_STROBE) |-> cnt == st_r.tim.w_strobe && !write_strobe_n_o;
    endproperty
    a_strobe_load: assert property (p_strobe_load) else $error("Strobe count wrong.");

    property p_strobe_low;
        (st_r.phase == ST_STROBE) |-> !write_strobe_n_o;
    endproperty
    a_strobe_low: assert property (p_strobe_low) else $error("Strobe not low.");

    property p_hold_we;
        (st_r.phase == ST_STROBE) && (cnt == CNT_ZERO) |=> write_strobe_n_o
            && (st_r.phase == ST_HOLD);
    endproperty
    a_hold_we: assert property (p_hold_we) else $error("Strobe not high in hold.");

    property p_ss_cs;
        st_r.tim.select_strobe && (st_r.phase inside {ST_SETUP, ST_HOLD})
            |-> chip_select_n_o == CS_IDLE;
    endproperty
    a_ss_cs: assert property (p_ss_cs) else $error("Select active outside strobe.");

    property p_sub_chain;
        s_sub_next |=> (st_r.phase == ST_SETUP) && $stable(st_r.tim)
            && !direction_indicator_n_o;
    endproperty
    a_sub_chain: assert property (p_sub_chain) else $error("Sub-access not chained.");

    property p_word_done;
        s_word_done |=> (st_r.phase == ST_IDLE) && done_o
            && chip_select_n_o == CS_IDLE && direction_indicator_n_o;
    endproperty
    a_word_done: assert property (p_word_done) else $error("Word end not released.");

    property p_pending;
        s_hold_end ##0 is_last && take && (req_i.space != st_r.req.space)
            |=> st_r.phase == ST_TURN;
    endproperty
    a_pending: assert property (p_pending) else $error("Pending request not taken.");

    property p_ta_one;
        $rose(st_r.phase == ST_TURN) && (cnt == CNT_ZERO) |=> st_r.phase == ST_SETUP;
    endproperty
    a_ta_one: assert property (p_ta_one) else $error("Turnaround length wrong.");

endmodule : amws_write_seq

// >>> inc/amws_pkg.sv
// Shared constants and types of the asynchronous memory write sequencer.
package amws_pkg;

    localparam int unsigned WA_W     = 20;
    localparam int unsigned XA_W     = WA_W + 2;
    localparam int unsigned XD_W     = 16;
    localparam int unsigned WD_W     = 32;
    localparam int unsigned SPACES   = 4;
    localparam int unsigned CNT_W    = 6;

    // A setup, strobe or hold field holding N gives N + 1 clock cycles of the phase.
    localparam logic [CNT_W-1:0] CNT_ZERO  = 6'h00;
    localparam logic [CNT_W-1:0] CNT_ONE   = 6'h01;
    localparam logic [1:0]       SUB_FIRST = 2'h0;
    localparam logic [1:0]       LAST_X8   = 2'h3;
    localparam logic [1:0]       LAST_X16  = 2'h1;
    localparam logic [1:0]       TA_ZERO   = 2'h0;
    localparam logic [SPACES-1:0] CS_IDLE  = 4'hf;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_TURN   = 5'h02,
        ST_SETUP  = 5'h04,
        ST_STROBE = 5'h08,
        ST_HOLD   = 5'h10
    } amws_phase_type;

    typedef struct packed {
        logic       select_strobe;
        logic       narrow8;
        logic [3:0] w_setup;
        logic [5:0] w_strobe;
        logic [2:0] w_hold;
        logic [1:0] turnaround_cycles;
    } amws_space_cfg_type;

    typedef struct packed {
        logic [1:0]      space;
        logic [1:0]      bank;
        logic [WA_W-1:0] word_addr;
        logic [WD_W-1:0] data;
    } amws_req_type;

    typedef struct packed {
        logic [XA_W-1:0]   external_address_bus;
        logic [1:0]        memory_page_lines;
        logic [XD_W-1:0]   external_data_bus;
        logic              data_oe;
        logic [SPACES-1:0] chip_select_n;
        logic              direction_indicator_n;
        logic              write_strobe_n;
        logic              output_enable_n;
    } amws_pins_type;

    localparam amws_pins_type PINS_RESET = '{
        external_address_bus:  '0,
        memory_page_lines:     2'h0,
        external_data_bus:     16'h0000,
        data_oe:               1'b0,
        chip_select_n:         CS_IDLE,
        direction_indicator_n: 1'b1,
        write_strobe_n:        1'b1,
        output_enable_n:       1'b1
    };

    typedef struct packed {
        logic [CNT_W-1:0] count;
    } amws_timer_state_type;

endpackage : amws_pkg

// >>> hdl/amws_phase_timer.sv
// Down counter that times one phase of the write sequence.
`timescale 1ns/1ns
module amws_phase_timer
    import amws_pkg::*;
(
    input  wire logic             clock_i,
    input  wire logic             rst_n_i,
    input  wire logic             load_i,
    input  wire logic [CNT_W-1:0] load_val_i,
    output logic      [CNT_W-1:0] count_o
);

    amws_timer_state_type st_r;
    amws_timer_state_type st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (load_i) begin
            st_nxt.count = load_val_i;
        end else if (st_r.count != CNT_ZERO) begin
            st_nxt.count = st_r.count - CNT_ONE;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign count_o = st_r.count;

endmodule : amws_phase_timer

// >>> verification/amws_mem_model.sv
// Behavioural external memory that records every completed write strobe.
`timescale 1ns/1ns
module amws_mem_model
    import amws_pkg::*;
(
    input  wire logic              clock_i,
    input  wire logic [SPACES-1:0] chip_select_n_i,
    input  wire logic              direction_indicator_n_i,
    input  wire logic              write_strobe_n_i,
    input  wire logic              output_enable_n_i,
    input  wire logic [XA_W-1:0]   external_address_bus_i,
    input  wire logic [1:0]        memory_page_lines_i,
    input  wire logic [XD_W-1:0]   external_data_bus_i,
    input  wire logic              external_data_bus_oe_i
);
    logic [XD_W-1:0] mem [logic [25:0]];
    logic            write_act;
    logic            act_q;
    logic [1:0]      space_sel;
    logic [25:0]     key_q;
    logic [XD_W-1:0] data_q;

    // A write counts only with the bus turned to writing and reads shut off.
    assign write_act = ~write_strobe_n_i & ~direction_indicator_n_i & output_enable_n_i
                       & (chip_select_n_i != CS_IDLE);

    always_comb begin
        space_sel = 2'h0;
        for (int s = SPACES - 1; s >= 0; s--) begin
            if (!chip_select_n_i[s]) begin
                space_sel = 2'(s);
            end
        end
    end

    // Sampling on the clock avoids racing the select against the strobe in select-strobe mode.
    // An undriven data bus is stored inverted so that a missing drive shows up as wrong data.
    always @(posedge clock_i) begin
        if (write_act) begin
            key_q  <= {space_sel, memory_page_lines_i, external_address_bus_i};
            data_q <= external_data_bus_oe_i ? external_data_bus_i : ~external_data_bus_i;
        end else if (act_q) begin
            mem[key_q] = data_q;
        end
        act_q <= write_act;
    end
endmodule : amws_mem_model

// >>> verification/async_memory_write_sequencer_tb_top.sv
// Self-checking bench of the asynchronous memory write sequencer.
`timescale 1ns/1ns
module async_memory_write_sequencer_tb_top
    import amws_pkg::*;
;
    localparam int LEN = 1024;
    logic                            clock_i;
    logic                            rst_n_i;
    amws_space_cfg_type [SPACES-1:0] chip_space_config_i;
    logic                            req_valid_i;
    amws_req_type                    req_i;
    logic                            req_ready_o;
    logic                            done_o;
    logic [XA_W-1:0]                 external_address_bus_o;
    logic [1:0]                      memory_page_lines_o;
    logic [XD_W-1:0]                 external_data_bus_o;
    logic                            external_data_bus_oe_o;
    logic [SPACES-1:0]               chip_select_n_o;
    logic                            direction_indicator_n_o;
    logic                            write_strobe_n_o;
    logic                            output_enable_n_o;
    int                              num_errors;
    int                              checked;

    amws_write_seq dut (.clock_i, .rst_n_i, .chip_space_config_i, .req_valid_i, .req_i,
        .req_ready_o, .done_o, .external_address_bus_o, .memory_page_lines_o,
        .external_data_bus_o, .external_data_bus_oe_o, .chip_select_n_o,
        .direction_indicator_n_o, .write_strobe_n_o, .output_enable_n_o);

    amws_mem_model mem_model (.clock_i, .chip_select_n_i(chip_select_n_o),
        .direction_indicator_n_i(direction_indicator_n_o), .write_strobe_n_i(write_strobe_n_o),
        .output_enable_n_i(output_enable_n_o), .external_address_bus_i(external_address_bus_o),
        .memory_page_lines_i(memory_page_lines_o), .external_data_bus_i(external_data_bus_o),
        .external_data_bus_oe_i(external_data_bus_oe_o));

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic fail(input string msg);
        num_errors++;
        $display("CHECK FAILED at %0t: %s", $time, msg);
    endtask : fail

    function automatic amws_space_cfg_type mk(input logic ss, input logic n8, input logic [3:0] s,
                                             input logic [5:0] st, input logic [2:0] h,
                                             input logic [1:0] ta);
        return '{ss, n8, s, st, h, ta};
    endfunction : mk

    function automatic amws_req_type mkr(input logic [1:0] sp, input logic [1:0] bk,
                                         input logic [WA_W-1:0] wa, input logic [WD_W-1:0] d);
        return '{sp, bk, wa, d};
    endfunction : mkr

    // Predicts every pin cycle by cycle from the timing fields, offers the requests back to
    // back, and compares; alt replaces the config of the first request's space at cycle alt_at.
    task automatic run(input amws_req_type rq [3], input int n, input int alt_at,
                       input amws_space_cfg_type alt);
        amws_pins_type                   e [LEN];
        logic                            e_done [LEN];
        logic                            e_rdy [LEN];
        logic [41:0]                     mq [$];
        amws_space_cfg_type [SPACES-1:0] orig;
        amws_space_cfg_type              cc;
        amws_pins_type                   got;
        amws_req_type                    r;
        int                              t;
        int                              s0;
        int                              p;
        int                              j;
        int                              ph;
        int                              sent;
        logic                            pend;
        logic                            stb;
        // Let the caller's non-blocking config write settle before it is copied.
        @(posedge clock_i);
        orig = chip_space_config_i;
        t = 1;
        foreach (e[k]) begin
            e[k] = PINS_RESET;
            e_done[k] = 1'b0;
            e_rdy[k] = 1'b1;
        end
        for (int i = 0; i < n; i++) begin
            r = rq[i];
            cc = orig[r.space];
            s0 = t;
            if (i == 0 || rq[i-1].space != r.space) begin
                s0 = t + ((cc.turnaround_cycles == TA_ZERO) ? 1 : int'(cc.turnaround_cycles));
            end
            p = int'(cc.w_setup) + int'(cc.w_strobe) + int'(cc.w_hold) + 3;
            for (int k = s0; k < s0 + (cc.narrow8 ? 4 : 2) * p; k++) begin
                j = (k - s0) / p;
                ph = (k - s0) % p;
                stb = ph > int'(cc.w_setup) && ph <= int'(cc.w_setup) + int'(cc.w_strobe) + 1;
                e[k].external_address_bus = cc.narrow8 ? {r.word_addr, 2'(j)}
                                                       : {1'b0, r.word_addr, 1'(j)};
                e[k].memory_page_lines = r.bank;
                e[k].external_data_bus = cc.narrow8 ? {8'h00, r.data[8*j +: 8]}
                                                    : r.data[16*j +: 16];
                e[k].data_oe = 1'b1;
                e[k].direction_indicator_n = 1'b0;
                e[k].write_strobe_n = !stb;
                e[k].chip_select_n[r.space] = cc.select_strobe & !stb;
                if (ph == 0) begin
                    mq.push_back({r.space, r.bank, e[k].external_address_bus,
                                  e[k].external_data_bus});
                end
            end
            for (int k = t; k < s0 + (cc.narrow8 ? 4 : 2) * p - 1; k++) begin
                e_rdy[k] = 1'b0;
            end
            t = s0 + (cc.narrow8 ? 4 : 2) * p;
            e_done[t] = 1'b1;
        end
        mem_model.mem.delete();
        @(posedge clock_i);
        req_valid_i <= 1'b1;
        req_i <= rq[0];
        sent = 1;
        pend = 1'b0;
        for (int k = 0; k <= t + 2; k++) begin
            if (k > 0) begin
                @(posedge clock_i);
                if (pend) begin
                    if (sent < n) begin
                        req_i <= rq[sent];
                    end else begin
                        req_valid_i <= 1'b0;
                    end
                    sent++;
                end
                if (k == alt_at) begin
                    chip_space_config_i[rq[0].space] <= alt;
                end
            end
            #1;
            pend = (req_valid_i === 1'b1) && (req_ready_o === 1'b1);
            got = {external_address_bus_o, memory_page_lines_o, external_data_bus_o,
                   external_data_bus_oe_o, chip_select_n_o, direction_indicator_n_o,
                   write_strobe_n_o, output_enable_n_o};
            checked++;
            // Bits 6:0 are the selects, direction, write strobe and output enable.
            if (got[6:0] !== e[k][6:0] || done_o !== e_done[k]
                || req_ready_o !== e_rdy[k]) begin
                fail($sformatf("cycle %0d controls %h done %b", k, got[6:0], done_o));
            end
            if (e[k].data_oe) begin
                checked++;
                if (got[47:7] !== e[k][47:7]) begin
                    fail($sformatf("cycle %0d address, page or data %h", k, got[47:7]));
                end
            end
        end
        foreach (mq[q]) begin
            checked++;
            if (mem_model.mem.exists(mq[q][41:16]) == 0
                || mem_model.mem[mq[q][41:16]] !== mq[q][15:0]) begin
                fail($sformatf("memory word %h", mq[q][41:16]));
            end
        end
    endtask : run

    task automatic test_single_halfword();
        @(posedge clock_i);
        chip_space_config_i[0] <= mk(1'b0, 1'b0, 4'h0, 6'h00, 3'h0, 2'h1);
        run('{mkr(2'h0, 2'h1, 20'h12345, 32'hcafef00d), '0, '0}, 1, -1, '0);
        $display("test_single_halfword finished");
    endtask : test_single_halfword

    task automatic test_byte_device_longest();
        @(posedge clock_i);
        chip_space_config_i[1] <= mk(1'b0, 1'b1, 4'hf, 6'h3f, 3'h7, 2'h3);
        run('{mkr(2'h1, 2'h2, 20'hfffff, 32'h8c4a2e17), '0, '0}, 1, -1, '0);
        $display("test_byte_device_longest finished");
    endtask : test_byte_device_longest

    task automatic test_timing_frozen();
        @(posedge clock_i);
        chip_space_config_i[2] <= mk(1'b0, 1'b0, 4'h2, 6'h03, 3'h1, 2'h0);
        run('{mkr(2'h2, 2'h3, 20'h00001, 32'h5a5aa5a5), '0, '0}, 1, 5,
            mk(1'b0, 1'b0, 4'h0, 6'h00, 3'h0, 2'h0));
        $display("test_timing_frozen finished");
    endtask : test_timing_frozen

    task automatic test_same_space_chain();
        @(posedge clock_i);
        chip_space_config_i[0] <= mk(1'b0, 1'b0, 4'h1, 6'h02, 3'h1, 2'h3);
        run('{mkr(2'h0, 2'h0, 20'h00010, 32'h11112222), mkr(2'h0, 2'h0, 20'h00011, 32'h33334444),
              mkr(2'h0, 2'h1, 20'h00012, 32'h55556666)}, 3, -1, '0);
        $display("test_same_space_chain finished");
    endtask : test_same_space_chain

    task automatic test_space_switch();
        @(posedge clock_i);
        chip_space_config_i[0] <= mk(1'b0, 1'b1, 4'h0, 6'h01, 3'h0, 2'h2);
        chip_space_config_i[3] <= mk(1'b0, 1'b0, 4'h1, 6'h00, 3'h2, 2'h1);
        run('{mkr(2'h0, 2'h1, 20'h0abcd, 32'h01234567), mkr(2'h3, 2'h2, 20'h0abcd, 32'h89abcdef),
              mkr(2'h0, 2'h3, 20'h0abce, 32'hfedcba98)}, 3, -1, '0);
        $display("test_space_switch finished");
    endtask : test_space_switch

    task automatic test_select_strobe();
        @(posedge clock_i);
        chip_space_config_i[3] <= mk(1'b1, 1'b0, 4'h1, 6'h01, 3'h1, 2'h2);
        chip_space_config_i[2] <= mk(1'b1, 1'b1, 4'h0, 6'h00, 3'h0, 2'h1);
        run('{mkr(2'h3, 2'h0, 20'h70000, 32'hdeadbeef), mkr(2'h3, 2'h1, 20'h70001, 32'h0badc0de),
              mkr(2'h2, 2'h2, 20'h00777, 32'h13579bdf)}, 3, -1, '0);
        $display("test_select_strobe finished");
    endtask : test_select_strobe

    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end

    // The whole sequence needs well under a thousand cycles.
    initial begin
        #20000;
        fail("watchdog expired");
        report_and_stop();
    end

    initial begin
        num_errors = 0;
        checked = 0;
        rst_n_i = 1'b0;
        req_valid_i = 1'b0;
        req_i = '0;
        chip_space_config_i = '0;
        repeat (6) @(posedge clock_i);
        rst_n_i <= 1'b1;
        test_single_halfword();
        test_byte_device_longest();
        test_timing_frozen();
        test_same_space_chain();
        test_space_switch();
        test_select_strobe();
        report_and_stop();
    end
endmodule : async_memory_write_sequencer_tb_top
